// ==== rtl/ifd_decoder.sv ====
/*
  Instruction field decoder: splits each fetched 14-bit word into opcode and
  operand fields, registered one cycle after the word is offered.
  Assumes the fetch stage drives instr_word with instr_valid synchronous to clk.
*/
`include "ifd_cfg.svh"

module ifd_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From instruction fetch
  input wire logic instr_valid,
  input wire logic [`IFD_WORD_W-1:0] instr_word,
  // To execution and addressing
  output logic dec_valid,
  output ifd_pkg::ifd_format_t dec_format,
  output logic [`IFD_WORD_W-1:0] opcode,
  output logic dest_accum,
  output logic dest_file,
  output logic [`IFD_FILE_W-1:0] file_addr,
  output logic [`IFD_BIT_W-1:0] bit_pos,
  output logic [`IFD_MASK_W-1:0] bit_mask,
  output logic [`IFD_LIT_W-1:0] literal,
  output logic ptr_sel,
  output logic [`IFD_MODE_W-1:0] ptr_mode
);

  ifd_fields_if fld ();
  ifd_pkg::ifd_format_t fmt_cur;

  logic dec_valid_reg;
  ifd_pkg::ifd_format_t format_reg, format_next;
  logic [`IFD_WORD_W-1:0] opcode_reg, opcode_next;
  logic dest_accum_reg, dest_accum_next;
  logic dest_file_reg, dest_file_next;
  logic [`IFD_FILE_W-1:0] file_addr_reg, file_addr_next;
  logic [`IFD_BIT_W-1:0] bit_pos_reg, bit_pos_next;
  logic [`IFD_MASK_W-1:0] bit_mask_reg, bit_mask_next;
  logic [`IFD_LIT_W-1:0] literal_reg, literal_next;
  logic ptr_sel_reg, ptr_sel_next;
  logic [`IFD_MODE_W-1:0] ptr_mode_reg, ptr_mode_next;

  assign fld.word = instr_word;
  assign fmt_cur = fld.fmt;

  ifd_format_sel u_format_sel (
    .fld (fld)
  );

  // Opcode right-justified: the bits above the operand field
  function automatic logic [`IFD_WORD_W-1:0] top_bits(
    input logic [`IFD_WORD_W-1:0] w,
    input int unsigned n
  );
    return w >> n;
  endfunction

  // Operand zero-extended to the literal port width
  function automatic logic [`IFD_LIT_W-1:0] low_bits(
    input logic [`IFD_WORD_W-1:0] w,
    input int unsigned n
  );
    logic [`IFD_WORD_W-1:0] m;
    m = `IFD_WORD_W'((32'h1 << n) - 32'h1);
    return `IFD_LIT_W'(w & m);
  endfunction

  // Fields unused by a format are forced to zero so that downstream logic
  // never sees stale operands from an earlier word
  always_comb
  begin
    format_next = fmt_cur;
    opcode_next = instr_word;
    dest_accum_next = 1'b0;
    dest_file_next = 1'b0;
    file_addr_next = '0;
    bit_pos_next = '0;
    bit_mask_next = '0;
    literal_next = '0;
    ptr_sel_next = 1'b0;
    ptr_mode_next = '0;
    unique case (fmt_cur)
      ifd_pkg::IFD_FMT_BYTE:
      begin
        opcode_next = top_bits(instr_word, `IFD_BYTE_OPERAND_W);  // [RULE1]
        dest_file_next = instr_word[`IFD_DEST_BIT];  // [RULE2]
        dest_accum_next = ~instr_word[`IFD_DEST_BIT];  // [RULE2]
        file_addr_next = instr_word[`IFD_FILE_W-1:0];  // [RULE1]
      end
      ifd_pkg::IFD_FMT_BIT:
      begin
        opcode_next = top_bits(instr_word, `IFD_BIT_OPERAND_W);
        bit_pos_next = instr_word[`IFD_BIT_OPERAND_W-1:`IFD_FILE_W];  // [RULE3]
        bit_mask_next = `IFD_MASK_W'(1) << bit_pos_next;  // [RULE3]
        file_addr_next = instr_word[`IFD_FILE_W-1:0];  // [RULE3]
      end
      ifd_pkg::IFD_FMT_LIT:
      begin
        opcode_next = top_bits(instr_word, `IFD_LIT8_W);
        literal_next = low_bits(instr_word, `IFD_LIT8_W);  // [RULE4]
      end
      ifd_pkg::IFD_FMT_JUMP:
      begin
        opcode_next = top_bits(instr_word, `IFD_JUMP_W);  // [RULE5]
        literal_next = low_bits(instr_word, `IFD_JUMP_W);  // [RULE5]
      end
      ifd_pkg::IFD_FMT_PAGE:
      begin
        opcode_next = top_bits(instr_word, `IFD_PAGE_W);  // [RULE6]
        literal_next = low_bits(instr_word, `IFD_PAGE_W);  // [RULE6]
      end
      ifd_pkg::IFD_FMT_BANK:
      begin
        opcode_next = top_bits(instr_word, `IFD_BANK_W);  // [RULE7]
        literal_next = low_bits(instr_word, `IFD_BANK_W);  // [RULE7]
      end
      ifd_pkg::IFD_FMT_BRANCH:
      begin
        opcode_next = top_bits(instr_word, `IFD_BRANCH_W);  // [RULE8]
        literal_next = low_bits(instr_word, `IFD_BRANCH_W);  // [RULE8]
      end
      ifd_pkg::IFD_FMT_OFS:
      begin
        opcode_next = top_bits(instr_word, `IFD_OFS_OPERAND_W);
        ptr_sel_next = instr_word[`IFD_OFS_PTR_BIT];  // [RULE9]
        literal_next = low_bits(instr_word, `IFD_OFS_W);  // [RULE9]
      end
      ifd_pkg::IFD_FMT_INC:
      begin
        opcode_next = top_bits(instr_word, `IFD_INC_OPERAND_W);
        ptr_sel_next = instr_word[`IFD_INC_PTR_BIT];  // [RULE10]
        ptr_mode_next = instr_word[`IFD_MODE_W-1:0];  // [RULE10]
      end
      ifd_pkg::IFD_FMT_OPONLY:
      begin
        opcode_next = instr_word;  // [RULE11]
      end
      default:
      begin
        opcode_next = instr_word;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      dec_valid_reg <= 1'b0;
    else
      dec_valid_reg <= instr_valid;
  end

  // Fields hold their last decode while no word is offered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      format_reg <= ifd_pkg::IFD_FMT_BYTE;
      opcode_reg <= '0;
      dest_accum_reg <= 1'b0;
      dest_file_reg <= 1'b0;
      file_addr_reg <= '0;
      bit_pos_reg <= '0;
      bit_mask_reg <= '0;
      literal_reg <= '0;
      ptr_sel_reg <= 1'b0;
      ptr_mode_reg <= '0;
    end
    else if (instr_valid)
    begin
      format_reg <= format_next;
      opcode_reg <= opcode_next;
      dest_accum_reg <= dest_accum_next;
      dest_file_reg <= dest_file_next;
      file_addr_reg <= file_addr_next;
      bit_pos_reg <= bit_pos_next;
      bit_mask_reg <= bit_mask_next;
      literal_reg <= literal_next;
      ptr_sel_reg <= ptr_sel_next;
      ptr_mode_reg <= ptr_mode_next;
    end
  end

  assign dec_valid = dec_valid_reg;
  assign dec_format = format_reg;
  assign opcode = opcode_reg;
  assign dest_accum = dest_accum_reg;
  assign dest_file = dest_file_reg;
  assign file_addr = file_addr_reg;
  assign bit_pos = bit_pos_reg;
  assign bit_mask = bit_mask_reg;
  assign literal = literal_reg;
  assign ptr_sel = ptr_sel_reg;
  assign ptr_mode = ptr_mode_reg;

  byte_fields_a: assert property (@(posedge clk) disable iff (rst)  // [RULE1]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_BYTE) |=>
      (dec_format == ifd_pkg::IFD_FMT_BYTE
       && file_addr == $past(instr_word[`IFD_FILE_W-1:0])
       && opcode == `IFD_WORD_W'($past(instr_word[`IFD_WORD_W-1:`IFD_BYTE_OPERAND_W]))))
    else $error("byte format fields wrong");

  dest_route_a: assert property (@(posedge clk) disable iff (rst)  // [RULE2]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_BYTE) ##1 dec_valid |->
      (dest_file == $past(instr_word[`IFD_DEST_BIT]) && dest_accum != dest_file))
    else $error("destination routing wrong");

  bit_select_a: assert property (@(posedge clk) disable iff (rst)  // [RULE3]
    (dec_valid && dec_format == ifd_pkg::IFD_FMT_BIT) |->
      ($onehot(bit_mask) && bit_mask[bit_pos]
       && bit_pos == $past(instr_word[`IFD_BIT_OPERAND_W-1:`IFD_FILE_W])))
    else $error("bit position or mask wrong");

  literal_byte_a: assert property (@(posedge clk) disable iff (rst)  // [RULE4]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_LIT) |=>
      (literal == `IFD_LIT_W'($past(instr_word[`IFD_LIT8_W-1:0]))))
    else $error("8-bit literal wrong");

  jump_target_a: assert property (@(posedge clk) disable iff (rst)  // [RULE5]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_JUMP) |=>
      (literal == $past(instr_word[`IFD_JUMP_W-1:0])
       && opcode == `IFD_WORD_W'($past(instr_word[`IFD_WORD_W-1:`IFD_JUMP_W]))))
    else $error("jump target wrong");

  page_load_a: assert property (@(posedge clk) disable iff (rst)  // [RULE6]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_PAGE) |=>
      (literal == `IFD_LIT_W'($past(instr_word[`IFD_PAGE_W-1:0]))
       && opcode == `IFD_WORD_W'($past(instr_word[`IFD_WORD_W-1:`IFD_PAGE_W]))))
    else $error("page load fields wrong");

  bank_load_a: assert property (@(posedge clk) disable iff (rst)  // [RULE7]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_BANK) |=>
      (literal == `IFD_LIT_W'($past(instr_word[`IFD_BANK_W-1:0]))
       && opcode == `IFD_WORD_W'($past(instr_word[`IFD_WORD_W-1:`IFD_BANK_W]))))
    else $error("bank load fields wrong");

  branch_offset_a: assert property (@(posedge clk) disable iff (rst)  // [RULE8]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_BRANCH) |=>
      (literal == `IFD_LIT_W'($past(instr_word[`IFD_BRANCH_W-1:0]))
       && opcode == `IFD_WORD_W'($past(instr_word[`IFD_WORD_W-1:`IFD_BRANCH_W]))))
    else $error("branch offset wrong");

  ptr_offset_a: assert property (@(posedge clk) disable iff (rst)  // [RULE9]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_OFS) |=>
      (ptr_sel == $past(instr_word[`IFD_OFS_PTR_BIT])
       && literal == `IFD_LIT_W'($past(instr_word[`IFD_OFS_W-1:0]))))
    else $error("pointer offset fields wrong");

  ptr_incr_a: assert property (@(posedge clk) disable iff (rst)  // [RULE10]
    (instr_valid && fmt_cur == ifd_pkg::IFD_FMT_INC) |=>
      (ptr_sel == $past(instr_word[`IFD_INC_PTR_BIT])
       && ptr_mode == $past(instr_word[`IFD_MODE_W-1:0]) && literal == '0))
    else $error("pointer increment fields wrong");

  no_operand_a: assert property (@(posedge clk) disable iff (rst)  // [RULE11]
    (dec_valid && dec_format == ifd_pkg::IFD_FMT_OPONLY) |->
      (opcode == $past(instr_word) && literal == '0 && file_addr == '0
       && bit_mask == '0 && !ptr_sel && ptr_mode == '0 && !dest_file))
    else $error("opcode-only word carries operands");

  long_prefix_a: assert property (@(posedge clk) disable iff (rst)  // [RULE12]
    (instr_valid && instr_word[`IFD_WORD_W-1:`IFD_INC_OPERAND_W] == `IFD_PFX_INC)
      ##1 dec_valid |->
      dec_format == ifd_pkg::IFD_FMT_INC)
    else $error("shorter prefix won over longer one");

  hold_idle_a: assert property (@(posedge clk) disable iff (rst)
    (dec_valid && !instr_valid) |=> (!dec_valid && $stable(opcode)
      && $stable(dec_format) && $stable(literal)))
    else $error("fields changed without a word");

endmodule

// ==== rtl/ifd_cfg.svh ====
/*
  Field positions, widths and opcode prefixes of the 14-bit instruction word.
  Assumes it is included by every design file of the field decoder except the type package.
*/
// What this block does
// RULE1: Byte format: opcode bits 13..8, destination bit 7, file address bits 6..0.
// RULE2: Destination bit 0 routes result to accumulator, 1 back to file register.
// RULE3: Bit format: 3-bit bit position selecting one bit, plus 7-bit file address.
// RULE4: General literal format: 8-bit immediate from the low bits.
// RULE5: Jump and call: 11-bit target bits 10..0, opcode bits 13..11.
// RULE6: Page load: 7-bit immediate bits 6..0, opcode bits 13..7.
// RULE7: Bank load: 5-bit immediate bits 4..0, opcode bits 13..5.
// RULE8: Relative branch: 9-bit offset bits 8..0, opcode bits 13..9.
// RULE9: Pointer offset: pointer select field plus 6-bit immediate offset in low bits.
// RULE10: Pointer increment: pointer select field plus 2-bit mode in lowest bits.
// RULE11: Opcode-only words: all 14 bits are opcode, every operand output stays zero.
// RULE12: Format chosen from leading bits, longer prefixes first, exactly one format.
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH

`define IFD_WORD_W 14
`define IFD_LIT_W 11
`define IFD_FILE_W 7
`define IFD_BIT_W 3
`define IFD_MASK_W 8
`define IFD_MODE_W 2

// Operand widths; each except IFD_OFS_W also marks where the opcode starts
`define IFD_BYTE_OPERAND_W 8
`define IFD_BIT_OPERAND_W 10
`define IFD_LIT8_W 8
`define IFD_JUMP_W 11
`define IFD_PAGE_W 7
`define IFD_BANK_W 5
`define IFD_BRANCH_W 9
`define IFD_OFS_OPERAND_W 7
`define IFD_OFS_W 6
`define IFD_INC_OPERAND_W 3

// Single-bit fields
`define IFD_DEST_BIT 7
`define IFD_OFS_PTR_BIT 6
`define IFD_INC_PTR_BIT 2

// Lowest bit of the two-bit class prefix shared by jump, bit and literal words
`define IFD_CLASS_POS 12

// Opcode prefixes, compared against the word above each format's operand field; opcode-only compares bits 13..5, jump, bit and literal bits 13..12 only
`define IFD_PFX_INC 11'h002
`define IFD_PFX_OPONLY 9'h000
`define IFD_PFX_BANK 9'h001
`define IFD_PFX_OFS 7'h62
`define IFD_PFX_PAGE 7'h63
`define IFD_PFX_BRANCH 5'h19
`define IFD_PFX_JUMP 2'h2
`define IFD_PFX_BIT 2'h1
`define IFD_PFX_LIT 2'h3

`endif

// ==== rtl/ifd_pkg.sv ====
/*
  Types shared by the instruction field decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ifd_pkg;

  typedef enum logic [3:0] {
    IFD_FMT_BYTE = 4'h0,
    IFD_FMT_BIT = 4'h1,
    IFD_FMT_LIT = 4'h2,
    IFD_FMT_JUMP = 4'h3,
    IFD_FMT_PAGE = 4'h4,
    IFD_FMT_BANK = 4'h5,
    IFD_FMT_BRANCH = 4'h6,
    IFD_FMT_OFS = 4'h7,
    IFD_FMT_INC = 4'h8,
    IFD_FMT_OPONLY = 4'h9
  } ifd_format_t;

endpackage

// ==== rtl/ifd_fields_if.sv ====
/*
  Carrier between the decoder top and its format selector.
  Assumes ifd_pkg is compiled first.
*/
`include "ifd_cfg.svh"

interface ifd_fields_if;
  logic [`IFD_WORD_W-1:0] word;
  ifd_pkg::ifd_format_t fmt;

  modport select (input word, output fmt);
  modport user (output word, input fmt);
endinterface

// ==== rtl/ifd_format_sel.sv ====
/*
  Combinational format classifier for one instruction word.
  Assumes the word is stable for the cycle in which fmt is used.
*/
`include "ifd_cfg.svh"

module ifd_format_sel (
  // Word in, format out
  ifd_fields_if.select fld
);

  // Priority chain: the increment prefix lives inside the opcode-only range,
  // so it must be tested before the shorter prefix swallows it
  always_comb
  begin
    if (fld.word[`IFD_WORD_W-1:`IFD_INC_OPERAND_W] == `IFD_PFX_INC)  // [RULE12]
      fld.fmt = ifd_pkg::IFD_FMT_INC;
    else if (fld.word[`IFD_WORD_W-1:`IFD_BANK_W] == `IFD_PFX_BANK)
      fld.fmt = ifd_pkg::IFD_FMT_BANK;
    else if (fld.word[`IFD_WORD_W-1:`IFD_BANK_W] == `IFD_PFX_OPONLY)
      fld.fmt = ifd_pkg::IFD_FMT_OPONLY;
    else if (fld.word[`IFD_WORD_W-1:`IFD_OFS_OPERAND_W] == `IFD_PFX_OFS)
      fld.fmt = ifd_pkg::IFD_FMT_OFS;
    else if (fld.word[`IFD_WORD_W-1:`IFD_PAGE_W] == `IFD_PFX_PAGE)
      fld.fmt = ifd_pkg::IFD_FMT_PAGE;
    else if (fld.word[`IFD_WORD_W-1:`IFD_BRANCH_W] == `IFD_PFX_BRANCH)
      fld.fmt = ifd_pkg::IFD_FMT_BRANCH;
    else if (fld.word[`IFD_WORD_W-1:`IFD_CLASS_POS] == `IFD_PFX_JUMP)
      fld.fmt = ifd_pkg::IFD_FMT_JUMP;
    else if (fld.word[`IFD_WORD_W-1:`IFD_CLASS_POS] == `IFD_PFX_BIT)
      fld.fmt = ifd_pkg::IFD_FMT_BIT;
    else if (fld.word[`IFD_WORD_W-1:`IFD_CLASS_POS] == `IFD_PFX_LIT)
      fld.fmt = ifd_pkg::IFD_FMT_LIT;
    else
      fld.fmt = ifd_pkg::IFD_FMT_BYTE;
  end

endmodule

// ==== tb/ifd_fetch_model.sv ====
/*
  Behavioural fetch stage that offers 14-bit words to the field decoder.
  Assumes the bench calls offer once per falling clock edge.
*/
`include "ifd_cfg.svh"

module ifd_fetch_model (
  // Clock
  input wire logic clk,
  // To the decoder
  output logic instr_valid,
  output logic [`IFD_WORD_W-1:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    instr_valid = 1'b0;
    instr_word = '0;
  end

  // When idle the word is scrambled so a decoder that ignores valid shows it
  task automatic offer(input logic v, input logic [`IFD_WORD_W-1:0] w);
    instr_valid = v;
    instr_word = v ? w : ~instr_word;
  endtask
endmodule

// ==== tb/instruction_field_decoder_tb_top.sv ====
/*
  Self-checking bench for the instruction field decoder: corner words, idle
  holds, mid-run reset and seeded random traffic.
  Assumes the rtl package, interface and decoder are compiled first.
*/
`include "ifd_cfg.svh"

module instruction_field_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    ifd_pkg::ifd_format_t fmt;
    logic [13:0] opc;
    logic da;
    logic df;
    logic [6:0] fa;
    logic [2:0] bp;
    logic [7:0] bm;
    logic [10:0] lit;
    logic ps;
    logic [1:0] pm;
  } ifd_exp_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid;
  logic [`IFD_WORD_W-1:0] instr_word;
  logic dec_valid;
  ifd_pkg::ifd_format_t dec_format;
  logic [`IFD_WORD_W-1:0] opcode;
  logic dest_accum;
  logic dest_file;
  logic [`IFD_FILE_W-1:0] file_addr;
  logic [`IFD_BIT_W-1:0] bit_pos;
  logic [`IFD_MASK_W-1:0] bit_mask;
  logic [`IFD_LIT_W-1:0] literal;
  logic ptr_sel;
  logic [`IFD_MODE_W-1:0] ptr_mode;
  int fails = 0;
  int n_tests = 0;
  ifd_exp_t exp_f;
  logic exp_v = 1'b0;

  always #5 clk = ~clk;

  ifd_fetch_model fetch_u (.clk(clk), .instr_valid(instr_valid), .instr_word(instr_word));

  ifd_decoder dut_u (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .dec_valid(dec_valid), .dec_format(dec_format), .opcode(opcode),
    .dest_accum(dest_accum), .dest_file(dest_file), .file_addr(file_addr),
    .bit_pos(bit_pos), .bit_mask(bit_mask), .literal(literal),
    .ptr_sel(ptr_sel), .ptr_mode(ptr_mode)
  );

  function automatic ifd_exp_t reset_exp();
    ifd_exp_t e;
    e = '0;
    e.fmt = ifd_pkg::IFD_FMT_BYTE;
    return e;
  endfunction

  // Longer prefixes are tried first so each word lands in exactly one format
  function automatic ifd_exp_t expect_of(input logic [13:0] w);
    ifd_exp_t e;
    e = reset_exp();
    if (w[13:3] == 11'h002)
    begin
      e.fmt = ifd_pkg::IFD_FMT_INC; e.opc = w >> 3; e.ps = w[2]; e.pm = w[1:0];
    end
    else if (w[13:5] == 9'h001)
    begin
      e.fmt = ifd_pkg::IFD_FMT_BANK; e.opc = w >> 5; e.lit = 11'(w[4:0]);
    end
    else if (w[13:5] == 9'h000)
    begin
      e.fmt = ifd_pkg::IFD_FMT_OPONLY; e.opc = w;
    end
    else if (w[13:7] == 7'h62)
    begin
      e.fmt = ifd_pkg::IFD_FMT_OFS; e.opc = w >> 7; e.ps = w[6]; e.lit = 11'(w[5:0]);
    end
    else if (w[13:7] == 7'h63)
    begin
      e.fmt = ifd_pkg::IFD_FMT_PAGE; e.opc = w >> 7; e.lit = 11'(w[6:0]);
    end
    else if (w[13:9] == 5'h19)
    begin
      e.fmt = ifd_pkg::IFD_FMT_BRANCH; e.opc = w >> 9; e.lit = 11'(w[8:0]);
    end
    else if (w[13:12] == 2'h2)
    begin
      e.fmt = ifd_pkg::IFD_FMT_JUMP; e.opc = w >> 11; e.lit = w[10:0];
    end
    else if (w[13:12] == 2'h1)
    begin
      e.fmt = ifd_pkg::IFD_FMT_BIT; e.opc = w >> 10; e.fa = w[6:0];
      e.bp = w[9:7]; e.bm = 8'h01 << w[9:7];
    end
    else if (w[13:12] == 2'h3)
    begin
      e.fmt = ifd_pkg::IFD_FMT_LIT; e.opc = w >> 8; e.lit = 11'(w[7:0]);
    end
    else
    begin
      e.opc = w >> 8; e.da = ~w[7]; e.df = w[7]; e.fa = w[6:0];
    end
    return e;
  endfunction

  task automatic bad(input string m);
    fails++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  task automatic check_outputs();
    n_tests++;
    if (dec_valid !== exp_v) bad("valid timing");
    if (dec_format !== exp_f.fmt) bad("format");
    if (opcode !== exp_f.opc) bad("opcode");
    if (dest_accum !== exp_f.da || dest_file !== exp_f.df) bad("destination");
    if (file_addr !== exp_f.fa) bad("file address");
    if (bit_pos !== exp_f.bp || bit_mask !== exp_f.bm) bad("bit position");
    if (literal !== exp_f.lit) bad("literal");
    if (ptr_sel !== exp_f.ps) bad("pointer select");
    if (ptr_mode !== exp_f.pm) bad("pointer mode");
  endtask

  // Checks the previous edge's result, then drives the next cycle
  task automatic step(input logic r, input logic v, input logic [13:0] w);
    @(negedge clk);
    check_outputs();
    rst = r;
    fetch_u.offer(v, w);
    if (r)
    begin
      exp_f = reset_exp();
      exp_v = 1'b0;
    end
    else
    begin
      exp_v = v;
      if (v) exp_f = expect_of(w);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  logic [13:0] corners [27] = '{14'h0000, 14'h000f, 14'h0010, 14'h0017, 14'h0018,
    14'h001f, 14'h0020, 14'h003f, 14'h0040, 14'h0080, 14'h00ff, 14'h1000, 14'h1f80,
    14'h2000, 14'h2fff, 14'h3000, 14'h30ff, 14'h3100, 14'h317f, 14'h3180, 14'h31ff,
    14'h3200, 14'h33ff, 14'h3400, 14'h3fff, 14'h0015, 14'h0012};

  initial
  begin
    exp_f = reset_exp();
    void'($urandom(50001));
    repeat (8) step(1'b1, 1'b0, 14'h0000);
    foreach (corners[i]) step(1'b0, 1'b1, corners[i]);
    $display("test corner_formats done");
    repeat (4) step(1'b0, 1'b0, 14'h0000);
    $display("test idle_hold done");
    step(1'b0, 1'b1, 14'h2abc);
    step(1'b1, 1'b0, 14'h0000);
    step(1'b0, 1'b1, 14'h1b85);
    step(1'b0, 1'b0, 14'h0000);
    $display("test mid_reset done");
    repeat (3000) step(1'b0, ($urandom % 4) != 0, 14'($urandom));
    step(1'b0, 1'b0, 14'h0000);
    $display("test random_words done");
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad("run did not finish in time");
    final_report();
  end
endmodule
